/* File: inc/speed_ramp_pkg.sv */
package speed_ramp_pkg;

	// Data and address widths of the parameter port, and the ramp counter width
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;
	localparam int CNT_W  = 24;

	// Parameter register indices, then the read-only status and speed words
	localparam logic [ADDR_W-1:0] REG_MODE        = 8'h00;
	localparam logic [ADDR_W-1:0] REG_ZST_CFG     = 8'h01;
	localparam logic [ADDR_W-1:0] REG_PRESET1     = 8'h02;
	localparam logic [ADDR_W-1:0] REG_PRESET4     = 8'h05;
	localparam logic [ADDR_W-1:0] REG_RAMP_UP     = 8'h06;
	localparam logic [ADDR_W-1:0] REG_RAMP_DOWN   = 8'h07;
	localparam logic [ADDR_W-1:0] REG_LIMIT_EN    = 8'h08;
	localparam logic [ADDR_W-1:0] REG_STOP_METHOD = 8'h09;
	localparam logic [ADDR_W-1:0] REG_WARN_SEL    = 8'h0a;
	localparam logic [ADDR_W-1:0] REG_ZERO_THR    = 8'h0b;
	localparam logic [ADDR_W-1:0] REG_ROT_THR     = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_OVS_1       = 8'h0d;
	localparam logic [ADDR_W-1:0] REG_OVS_2       = 8'h0e;
	localparam logic [ADDR_W-1:0] REG_TRQ_1       = 8'h0f;
	localparam logic [ADDR_W-1:0] REG_TRQ_2       = 8'h10;
	localparam logic [ADDR_W-1:0] REG_DEV_1       = 8'h11;
	localparam logic [ADDR_W-1:0] REG_DEV_2       = 8'h12;
	localparam logic [ADDR_W-1:0] REG_STATUS      = 8'h13;
	localparam logic [ADDR_W-1:0] REG_SPEED_CMD   = 8'h14;
	localparam logic [ADDR_W-1:0] REG_MOTOR_SPEED = 8'h15;
	localparam int                NCFG            = 19;

	// Setting codes
	localparam logic [DATA_W-1:0] MODE_PRESET_SPEED = 16'h0001;
	localparam logic [DATA_W-1:0] ZST_ZERO_SPEED    = 16'h0001;
	localparam logic [DATA_W-1:0] ZST_TORQUE_SW     = 16'h0002;
	localparam logic [DATA_W-1:0] WARN_ZERO_SPEED   = 16'h0001;
	localparam logic [DATA_W-1:0] STOP_BRAKE        = 16'h0000;
	localparam logic [DATA_W-1:0] STOP_COAST        = 16'h0001;

	// Setpoint range, +/-20000 r/min
	localparam logic signed [DATA_W-1:0] SPEED_MAX = 16'sh4e20;
	localparam logic signed [DATA_W-1:0] SPEED_MIN = -16'sh4e20;

	// Ramp timing: one count is 2 ms for 1000 r/min
	localparam int CLK_PERIOD_NS = 50;
	localparam int RAMP_UNIT_NS  = 2000000;
	localparam int RAMP_REF_RPM  = 1000;
	localparam int CYC_PER_RPM   =
		RAMP_UNIT_NS / (RAMP_REF_RPM * CLK_PERIOD_NS);

	// Reset values
	localparam logic [DATA_W-1:0] RST_MODE     = 16'h0001;
	localparam logic [DATA_W-1:0] RST_ZST_CFG  = 16'h0001;
	localparam logic [DATA_W-1:0] RST_LIMIT_EN = 16'h0001;
	localparam logic [DATA_W-1:0] RST_WARN_SEL = 16'h0001;
	localparam logic [DATA_W-1:0] RST_ZERO_THR = 16'h000a;
	localparam logic [DATA_W-1:0] RST_ROT_THR  = 16'h0014;
	localparam logic [DATA_W-1:0] RST_OVS      = 16'h2710;
	localparam logic [DATA_W-1:0] RST_TRQ      = 16'h012c;
	localparam logic [DATA_W-1:0] RST_DEV      = 16'h0064;
	localparam logic [DATA_W-1:0] RST_OTHER    = 16'h0000;

	// Run sequence states
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_ARMED = 4'h2,
		ST_RUN   = 4'h4,
		ST_STOP  = 4'h8
	} run_state_t;

	// Discrete command inputs from the controller
	typedef struct packed {
		logic run;
		logic zero_desig;
		logic sel_bit0;
		logic sel_bit1;
		logic fwd_limit;
		logic rev_limit;
		logic tl_switch;
	} discrete_t;

	// Active limit set
	typedef struct packed {
		logic [DATA_W-1:0] overspeed;
		logic [DATA_W-1:0] torque;
		logic [DATA_W-1:0] dev_overflow;
	} limit_set_t;

	// Reset value of each parameter register
	function automatic logic [DATA_W-1:0] reg_reset(input int idx);
		unique case (idx)
			0:       return RST_MODE;
			1:       return RST_ZST_CFG;
			8:       return RST_LIMIT_EN;
			10:      return RST_WARN_SEL;
			11:      return RST_ZERO_THR;
			12:      return RST_ROT_THR;
			13, 14:  return RST_OVS;
			15, 16:  return RST_TRQ;
			17, 18:  return RST_DEV;
			default: return RST_OTHER;
		endcase
	endfunction : reg_reset

endpackage : speed_ramp_pkg

/* File: rtl/preset_speed_ctrl.sv */
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
module preset_speed_ctrl (
	input  wire logic                                   mclk_in,
	input  wire logic                                   rstn_in,
	input  wire speed_ramp_pkg::discrete_t              cmd_in,
	input  wire logic signed [speed_ramp_pkg::DATA_W-1:0] motor_speed_in,
	input  wire logic [speed_ramp_pkg::ADDR_W-1:0]      addr_in,
	input  wire logic [speed_ramp_pkg::DATA_W-1:0]      wr_data_in,
	input  wire logic                                   wr_strobe_in,
	input  wire logic                                   rd_strobe_in,
	output logic [speed_ramp_pkg::DATA_W-1:0]           rd_data_out,
	output logic signed [speed_ramp_pkg::DATA_W-1:0]    speed_cmd_out,
	output logic                                        zero_speed_out,
	output logic                                        rotation_detected_out,
	output logic                                        dyn_brake_out,
	output logic                                        free_run_out,
	output speed_ramp_pkg::limit_set_t                  limit_set_out
);
	import speed_ramp_pkg::*;

	typedef struct packed {
		discrete_t                     sync1;
		discrete_t                     sync2;
		logic                          desig_prev;
		run_state_t                    fsm;
		logic [NCFG-1:0][DATA_W-1:0]   regs;
		logic [DATA_W-1:0]             rdata;
		logic                          zero_speed;
		logic                          rotating;
		logic                          brake;
		logic                          coast;
		limit_set_t                    limits;
	} ctl_state_t;

	ctl_state_t s;
	ctl_state_t next_s;

	logic signed [DATA_W-1:0] ramp_target;
	logic signed [DATA_W-1:0] ramp_speed;
	logic                     ramp_force_zero;
	logic                     mode_ok;
	logic                     desig_used;
	logic                     desig_on;
	logic                     desig_rise;
	logic                     fwd_block;
	logic                     rev_block;
	logic                     limit_stop;
	logic                     tl_swap;
	logic [1:0]               sel;
	logic signed [DATA_W-1:0] preset;
	logic [DATA_W-1:0]        status;

	// Limit a written setpoint to the legal range
	function automatic logic [DATA_W-1:0] clamp_speed(
		input logic [DATA_W-1:0] v);
		if ($signed(v) > SPEED_MAX) begin
			return SPEED_MAX;
		end else if ($signed(v) < SPEED_MIN) begin
			return SPEED_MIN;
		end
		return v;
	endfunction : clamp_speed

	// Magnitude of a signed speed
	function automatic logic [DATA_W-1:0] speed_mag(
		input logic signed [DATA_W-1:0] v);
		return (v < 0) ? DATA_W'(-v) : DATA_W'(v);
	endfunction : speed_mag

	// Whether an index names one of the setpoint registers
	function automatic logic is_preset(input logic [ADDR_W-1:0] a);
		return (a >= REG_PRESET1) && (a <= REG_PRESET4);
	endfunction : is_preset

	// Ramp generator holding the live speed command
	speed_ramp u_ramp (
		.mclk_in       (mclk_in),
		.rstn_in       (rstn_in),
		.target_in     (ramp_target),
		.up_time_in    (s.regs[REG_RAMP_UP]),
		.down_time_in  (s.regs[REG_RAMP_DOWN]),
		.force_zero_in (ramp_force_zero),
		.speed_out     (ramp_speed)
	);

	// Decoded configuration and synchronised inputs
	always_comb begin
		mode_ok = s.regs[REG_MODE] == MODE_PRESET_SPEED;
		desig_used = s.regs[REG_ZST_CFG] == ZST_ZERO_SPEED;
		desig_on = desig_used ? s.sync2.zero_desig : 1'b1;
		desig_rise = desig_used ? (s.sync2.zero_desig && !s.desig_prev)
			: 1'b1;
		tl_swap = (s.regs[REG_ZST_CFG] == ZST_TORQUE_SW) &&
			s.sync2.tl_switch;
		fwd_block = s.regs[REG_LIMIT_EN][0] && !s.sync2.fwd_limit;
		rev_block = s.regs[REG_LIMIT_EN][0] && !s.sync2.rev_limit;
	end

	// Setpoint selection from the two select inputs
	always_comb begin
		sel = {s.sync2.sel_bit1, s.sync2.sel_bit0};
		preset = $signed(s.regs[32'(REG_PRESET1) + 32'(sel)]);
	end

	// Ramp target and forced stop on a blocked direction
	always_comb begin
		ramp_target = (s.fsm == ST_RUN) ? preset : '0;
		if (fwd_block && ramp_target > 0) begin
			ramp_target = '0;
		end
		if (rev_block && ramp_target < 0) begin
			ramp_target = '0;
		end
		ramp_force_zero = (fwd_block && ramp_speed > 0) ||
			(rev_block && ramp_speed < 0);
		limit_stop = (fwd_block && motor_speed_in > 0) ||
			(rev_block && motor_speed_in < 0);
	end

	// Status word seen by software
	always_comb begin
		status = '0;
		status[3:0] = s.fsm;
		status[4] = s.zero_speed;
		status[5] = s.rotating;
		status[6] = fwd_block;
		status[7] = rev_block;
		status[8] = s.brake;
		status[9] = s.coast;
		status[10] = s.sync2.zero_desig;
		status[11] = s.sync2.run;
		status[12] = tl_swap;
	end

	// Next state of the whole control block
	always_comb begin
		next_s = s;
		next_s.sync1 = cmd_in;
		next_s.sync2 = s.sync1;
		next_s.desig_prev = s.sync2.zero_desig;
		next_s.rdata = '0;

		// Parameter writes, setpoints clamped into range
		if (wr_strobe_in && addr_in < ADDR_W'(NCFG)) begin
			if (is_preset(addr_in)) begin
				next_s.regs[addr_in] = clamp_speed(wr_data_in);
			end else begin
				next_s.regs[addr_in] = wr_data_in;
			end
		end

		// Read data stand one cycle after the read strobe
		if (rd_strobe_in) begin
			if (addr_in < ADDR_W'(NCFG)) begin
				next_s.rdata = s.regs[addr_in];
			end else if (addr_in == REG_STATUS) begin
				next_s.rdata = status;
			end else if (addr_in == REG_SPEED_CMD) begin
				next_s.rdata = ramp_speed;
			end else if (addr_in == REG_MOTOR_SPEED) begin
				next_s.rdata = motor_speed_in;
			end
		end

		// Run sequence: run first, then the designation edge
		unique case (s.fsm)
			ST_IDLE: begin
				if (s.sync2.run && mode_ok && !desig_used) begin
					next_s.fsm = ST_RUN;
				end else if (s.sync2.run && mode_ok) begin
					next_s.fsm = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (!s.sync2.run || !mode_ok) begin
					next_s.fsm = ST_IDLE;
				end else if (desig_rise) begin
					next_s.fsm = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!s.sync2.run || !mode_ok || !desig_on) begin
					next_s.fsm = ST_STOP;
				end
			end
			ST_STOP: begin
				if (s.sync2.run && mode_ok && desig_rise) begin
					next_s.fsm = ST_RUN;
				end else if (ramp_speed == '0) begin
					next_s.fsm = (s.sync2.run && mode_ok) ? ST_ARMED
						: ST_IDLE;
				end
			end
		endcase

		// Speed detection outputs
		next_s.zero_speed = (s.regs[REG_WARN_SEL] == WARN_ZERO_SPEED) &&
			(speed_mag(motor_speed_in) < s.regs[REG_ZERO_THR]);
		next_s.rotating =
			speed_mag(motor_speed_in) > s.regs[REG_ROT_THR];

		// Stop method while a blocked direction still moves
		next_s.brake = limit_stop &&
			(s.regs[REG_STOP_METHOD] == STOP_BRAKE);
		next_s.coast = limit_stop &&
			(s.regs[REG_STOP_METHOD] == STOP_COAST);

		// Primary or alternative limit set
		next_s.limits.overspeed = tl_swap ? s.regs[REG_OVS_2]
			: s.regs[REG_OVS_1];
		next_s.limits.torque = tl_swap ? s.regs[REG_TRQ_2]
			: s.regs[REG_TRQ_1];
		next_s.limits.dev_overflow = tl_swap ? s.regs[REG_DEV_2]
			: s.regs[REG_DEV_1];
	end

	// State register with parameter reset values
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s <= '0;
			s.fsm <= ST_IDLE;
			for (int i = 0; i < NCFG; i++) begin
				s.regs[i] <= reg_reset(i);
			end
			s.limits.overspeed <= RST_OVS;
			s.limits.torque <= RST_TRQ;
			s.limits.dev_overflow <= RST_DEV;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from flip-flops
	assign rd_data_out = s.rdata;
	assign speed_cmd_out = ramp_speed;
	assign zero_speed_out = s.zero_speed;
	assign rotation_detected_out = s.rotating;
	assign dyn_brake_out = s.brake;
	assign free_run_out = s.coast;
	assign limit_set_out = s.limits;

endmodule : preset_speed_ctrl

/* File: rtl/speed_ramp.sv */
`timescale 1ns/10ps
module speed_ramp (
	input  wire logic                                   mclk_in,
	input  wire logic                                   rstn_in,
	input  wire logic signed [speed_ramp_pkg::DATA_W-1:0] target_in,
	input  wire logic [speed_ramp_pkg::DATA_W-1:0]      up_time_in,
	input  wire logic [speed_ramp_pkg::DATA_W-1:0]      down_time_in,
	input  wire logic                                   force_zero_in,
	output logic signed [speed_ramp_pkg::DATA_W-1:0]    speed_out
);
	import speed_ramp_pkg::*;

	typedef struct packed {
		logic signed [DATA_W-1:0] speed;
		logic [CNT_W-1:0]         cnt;
	} ramp_state_t;

	ramp_state_t s;
	ramp_state_t next_s;
	logic        toward_zero;
	logic [DATA_W-1:0] time_sel;
	logic [CNT_W-1:0]  step_cycles;

	// One r/min step every time*40 cycles gives a constant slope
	always_comb begin
		next_s = s;
		toward_zero = (s.speed > 0 && target_in < s.speed) ||
			(s.speed < 0 && target_in > s.speed);
		time_sel = toward_zero ? down_time_in : up_time_in;
		step_cycles = CNT_W'({8'h00, time_sel} * CNT_W'(CYC_PER_RPM));
		if (force_zero_in) begin
			next_s.speed = '0;
			next_s.cnt = '0;
		end else if (s.speed == target_in) begin
			next_s.cnt = '0;
		end else if (time_sel == '0) begin
			next_s.speed = target_in;
			next_s.cnt = '0;
		end else if (s.cnt + 1'b1 >= step_cycles) begin
			next_s.cnt = '0;
			next_s.speed = (target_in > s.speed) ? s.speed + 16'sd1
				: s.speed - 16'sd1;
		end else begin
			next_s.cnt = s.cnt + 1'b1;
		end
	end

	// State register
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign speed_out = s.speed;

endmodule : speed_ramp

/* File: verif/motion_host.sv */
`timescale 1ns/10ps
module motion_host
	import speed_ramp_pkg::*;
(
	input  wire logic                      mclk_in,
	input  wire logic                      rstn_in,
	input  wire speed_ramp_pkg::discrete_t req_in,
	input  wire logic                      rude_in,
	input  wire logic signed [15:0]        speed_cmd_in,
	output speed_ramp_pkg::discrete_t      cmd_out,
	output logic signed [15:0]             motor_speed_out
);
	logic [3:0] run_age;

	// Controller levels and a motor that follows at 1 r/min per cycle
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			run_age <= 4'h0;
			cmd_out <= '0;
			motor_speed_out <= 16'sh0000;
		end else begin
			run_age <= req_in.run ? run_age + {3'h0, run_age != 4'hf} : 4'h0;
			cmd_out <= req_in;
			// Designation only once run has settled, unless told otherwise
			cmd_out.zero_desig <= req_in.zero_desig &&
				(rude_in || run_age > 7);
			if (motor_speed_out < speed_cmd_in)
				motor_speed_out <= motor_speed_out + 16'sd1;
			else if (motor_speed_out > speed_cmd_in)
				motor_speed_out <= motor_speed_out - 16'sd1;
		end
	end
endmodule : motion_host

/* File: verif/speed_cmd_props.sv */
`timescale 1ns/10ps
module speed_cmd_props
	import speed_ramp_pkg::*;
(
	input wire logic                mclk_in,
	input wire logic                rstn_in,
	input wire speed_ramp_pkg::discrete_t cmd_in,
	input wire logic signed [15:0]  motor_speed_in,
	input wire logic [7:0]          addr_in,
	input wire logic [15:0]         wr_data_in,
	input wire logic                wr_strobe_in,
	input wire logic                rd_strobe_in,
	input wire logic [15:0]         rd_data_out,
	input wire logic signed [15:0]  speed_cmd_out,
	input wire logic                zero_speed_out,
	input wire logic                rotation_detected_out,
	input wire logic                dyn_brake_out,
	input wire logic                free_run_out,
	input wire speed_ramp_pkg::limit_set_t limit_set_out
);
	logic [15:0] cfg [0:18];
	logic [3:0]  wq;
	logic [3:0]  mq;
	logic [3:0]  lq;
	logic [15:0] am;

	// Speed magnitude for the threshold flags
	assign am = motor_speed_in[15] ? -motor_speed_in : motor_speed_in;

	// Shadow settings and quiet-time counters after writes and changes
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < NCFG; i++)
				cfg[i] <= reg_reset(i);
			wq <= 4'h0;
			mq <= 4'h0;
			lq <= 4'h0;
		end else begin
			if (wr_strobe_in && addr_in < REG_STATUS)
				cfg[addr_in[4:0]] <= wr_data_in;
			wq <= wr_strobe_in ? 4'h0 : wq + {3'h0, wq != 4'hf};
			mq <= $changed(motor_speed_in) ? 4'h0 : mq + {3'h0, mq != 4'hf};
			lq <= (cmd_in.fwd_limit && cmd_in.rev_limit) ?
				lq + {3'h0, lq != 4'hf} : 4'h0;
		end
	end

	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);

	a_rot_flag: assert property (mq > 2 && wq > 2 |->
		rotation_detected_out == (am > cfg[12])) else $error("rotation flag");
	a_zero_flag: assert property (mq > 2 && wq > 2 |->
		zero_speed_out == (cfg[10] == WARN_ZERO_SPEED && am < cfg[11]))
		else $error("zero speed flag");
	a_fwd_block: assert property ((cfg[8][0] && !cmd_in.fwd_limit)[*5]
		|=> speed_cmd_out <= 0) else $error("forward not blocked");
	a_rev_block: assert property ((cfg[8][0] && !cmd_in.rev_limit)[*5]
		|=> speed_cmd_out >= 0) else $error("reverse not blocked");
	a_limit_swap: assert property ((cfg[1] == ZST_TORQUE_SW &&
		cmd_in.tl_switch && wq > 2)[*5] |=>
		limit_set_out == {cfg[14], cfg[16], cfg[18]}) else $error("swap");
	a_stop_kind: assert property ((dyn_brake_out || free_run_out) && wq > 2
		|-> dyn_brake_out != free_run_out &&
		free_run_out == (cfg[9] == STOP_COAST)) else $error("stop kind");
	a_ramp_slope: assert property ($changed(speed_cmd_out) && wq > 2
		&& lq > 5 && cfg[6] != 0 && cfg[7] != 0 |->
		speed_cmd_out == $past(speed_cmd_out) + 16'sd1 ||
		speed_cmd_out == $past(speed_cmd_out) - 16'sd1) else $error("slope");
	a_preset_range: assert property (rd_strobe_in &&
		addr_in inside {[REG_PRESET1:REG_PRESET4]} |=>
		$signed(rd_data_out) <= SPEED_MAX && $signed(rd_data_out) >= SPEED_MIN)
		else $error("preset out of range");

	c_brake: cover property (dyn_brake_out);
	c_coast: cover property (free_run_out);
	c_swap: cover property (cfg[1] == ZST_TORQUE_SW && cmd_in.tl_switch);
endmodule : speed_cmd_props

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	import speed_ramp_pkg::*;
	logic               mclk_in = 1'b0;
	logic               rstn_in = 1'b0;
	discrete_t          req = '{fwd_limit:1, rev_limit:1, default:0};
	discrete_t          cmd;
	logic               rude = 1'b0;
	logic signed [15:0] motor;
	logic signed [15:0] spd;
	logic [7:0]         addr = 8'h00;
	logic [15:0]        wd = 16'h0000;
	logic [15:0]        rdata;
	logic               wr_s = 1'b0;
	logic               rd_s = 1'b0;
	logic               zs, rot, brk, fre;
	limit_set_t         lset;
	int                 error_cnt = 0;
	int                 comparisons = 0;
	int                 c, i;
	logic [15:0]        pv [4] = '{16'h0064, 16'h00c8, 16'hfed4, 16'h0190};

	// Clock
	always #25 mclk_in = ~mclk_in;

	preset_speed_ctrl uut (.mclk_in(mclk_in), .rstn_in(rstn_in),
		.cmd_in(cmd), .motor_speed_in(motor), .addr_in(addr),
		.wr_data_in(wd), .wr_strobe_in(wr_s), .rd_strobe_in(rd_s),
		.rd_data_out(rdata), .speed_cmd_out(spd), .zero_speed_out(zs),
		.rotation_detected_out(rot), .dyn_brake_out(brk),
		.free_run_out(fre), .limit_set_out(lset));
	motion_host host_i (.mclk_in(mclk_in), .rstn_in(rstn_in), .req_in(req),
		.rude_in(rude), .speed_cmd_in(spd), .cmd_out(cmd),
		.motor_speed_out(motor));

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_in);
		addr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge mclk_in);
		wr_s <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge mclk_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge mclk_in);
		rd_s <= 1'b0;
		#1 chk(rdata, e);
	endtask : rd

	// Waits a bounded time for the speed command to reach a value
	task automatic wait_cmd(input logic [15:0] v);
		int n;
		n = 0;
		while (spd !== v && n < 5000) begin
			@(posedge mclk_in);
			#1 n++;
		end
		chk($unsigned(spd), v);
	endtask : wait_cmd

	// Cycles until the speed command next changes
	task automatic step_time(output int n);
		logic [15:0] s;
		s = spd;
		n = 0;
		while (spd === s && n < 1000) begin
			@(posedge mclk_in);
			#1 n++;
		end
	endtask : step_time

	task automatic test_done();
		$display("Mismatches %0d of %0d comparisons", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	// Watchdog against a hung sequence
	initial begin
		repeat (20000) @(posedge mclk_in);
		error_cnt++;
		test_done();
	end

	// Main sequence
	initial begin
		repeat (20) @(posedge mclk_in);
		rstn_in <= 1'b1;
		rd(REG_MODE, MODE_PRESET_SPEED);
		rd(REG_ZST_CFG, ZST_ZERO_SPEED);
		rd(REG_LIMIT_EN, RST_LIMIT_EN);
		rd(REG_ZERO_THR, RST_ZERO_THR);
		rd(REG_TRQ_1, RST_TRQ);
		rd(8'h20, 16'h0000);
		wr(REG_PRESET1, 16'h7530);
		rd(REG_PRESET1, 16'h4e20);
		wr(REG_PRESET1, 16'h8ad0);
		rd(REG_PRESET1, 16'hb1e0);
		for (i = 0; i < 4; i++)
			wr(REG_PRESET1 + i[7:0], pv[i]);
		@(posedge mclk_in) req.run <= 1'b1;
		repeat (10) @(posedge mclk_in);
		req.zero_desig <= 1'b1;
		wait_cmd(pv[0]);
		for (i = 0; i < 4; i++) begin
			@(posedge mclk_in);
			req.sel_bit0 <= i[0];
			req.sel_bit1 <= i[1];
			wait_cmd(pv[i]);
		end
		repeat (500) @(posedge mclk_in);
		#1 chk(rot, 1'b1);
		chk(zs, 1'b0);
		@(posedge mclk_in) req <= '{run:1, zero_desig:1, fwd_limit:1,
			rev_limit:1, default:0};
		repeat (320) @(posedge mclk_in);
		req.fwd_limit <= 1'b0;
		wait_cmd(16'h0000);
		repeat (3) @(posedge mclk_in);
		#1 chk(brk, 1'b1);
		wr(REG_STOP_METHOD, STOP_COAST);
		repeat (3) @(posedge mclk_in);
		#1 chk({brk, fre}, 2'b01);
		@(posedge mclk_in) req.sel_bit1 <= 1'b1;
		wait_cmd(pv[2]);
		@(posedge mclk_in) req.rev_limit <= 1'b0;
		wait_cmd(16'h0000);
		@(posedge mclk_in) req <= '{run:1, zero_desig:1, fwd_limit:1,
			default:0};
		wait_cmd(pv[0]);
		@(posedge mclk_in) req.rev_limit <= 1'b1;
		wr(REG_LIMIT_EN, 16'h0000);
		@(posedge mclk_in) req.fwd_limit <= 1'b0;
		repeat (20) @(posedge mclk_in);
		#1 chk(spd, pv[0]);
		@(posedge mclk_in) req.fwd_limit <= 1'b1;
		wr(REG_PRESET1, 16'h0000);
		repeat (120) @(posedge mclk_in);
		#1 chk({zs, rot}, 2'b10);
		wr(REG_WARN_SEL, 16'h0000);
		repeat (3) @(posedge mclk_in);
		#1 chk(zs, 1'b0);
		wr(REG_RAMP_UP, 16'h0001);
		wr(REG_RAMP_DOWN, 16'h0002);
		wr(REG_PRESET1, 16'h000a);
		wait_cmd(16'h0002);
		step_time(c);
		chk(c[15:0], 16'd40);
		wait_cmd(16'h000a);
		@(posedge mclk_in) req.zero_desig <= 1'b0;
		wait_cmd(16'h0008);
		step_time(c);
		chk(c[15:0], 16'd80);
		wait_cmd(16'h0000);
		@(posedge mclk_in) req.run <= 1'b0;
		repeat (20) @(posedge mclk_in);
		rude <= 1'b1;
		req.zero_desig <= 1'b1;
		repeat (10) @(posedge mclk_in);
		req.run <= 1'b1;
		repeat (300) @(posedge mclk_in);
		#1 chk(spd, 16'h0000);
		@(posedge mclk_in) req.zero_desig <= 1'b0;
		repeat (10) @(posedge mclk_in);
		req.zero_desig <= 1'b1;
		wait_cmd(16'h000a);
		wr(REG_ZST_CFG, ZST_TORQUE_SW);
		wr(REG_OVS_2, 16'h1111);
		wr(REG_TRQ_2, 16'h2222);
		wr(REG_DEV_2, 16'h3333);
		@(posedge mclk_in) req.tl_switch <= 1'b1;
		repeat (6) @(posedge mclk_in);
		#1 chk(lset, 48'h1111_2222_3333);
		@(posedge mclk_in) req.tl_switch <= 1'b0;
		repeat (6) @(posedge mclk_in);
		#1 chk(lset, {RST_OVS, RST_TRQ, RST_DEV});
		test_done();
	end
endmodule : tb_top

bind preset_speed_ctrl speed_cmd_props props_i (.mclk_in, .rstn_in,
	.cmd_in, .motor_speed_in, .addr_in, .wr_data_in, .wr_strobe_in,
	.rd_strobe_in, .rd_data_out, .speed_cmd_out, .zero_speed_out,
	.rotation_detected_out, .dyn_brake_out, .free_run_out, .limit_set_out);
